/* File: rtl/tcz_timer.sv */
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "tcz_regs.svh"
module tcz_timer
    import tcz_pkg::*;
(
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`TCZ_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Device pins and status
    input  wire logic                     external_count_input,
    input  wire logic                     sleep_mode,
    output logic                          overflow_irq
);

    tcz_ctrl_s    ctrl_reg;
    tcz_irq_s     irq_reg;
    tcz_count_t   cnt_reg;
    logic [7:0]   hbuf_reg;
    logic [7:0]   pre_reg;
    tcz_inhibit_t inh_reg;
    logic [31:0]  rdata_reg;
    logic         ext_meta_reg;
    logic         ext_sync_reg;
    logic         ext_prev_reg;
    logic         ext_tick_reg;

    // Bus decode
    logic hit_low, hit_high, hit_ictl, hit_tctl, hit_any;
    logic wr_en, rd_setup, wr_low;
    assign hit_low  = (paddr == `TCZ_OFF_LOW);
    assign hit_high = (paddr == `TCZ_OFF_HIGH);
    assign hit_ictl = (paddr == `TCZ_OFF_ICTL);
    assign hit_tctl = (paddr == `TCZ_OFF_TCTL);
    assign hit_any  = hit_low | hit_high | hit_ictl | hit_tctl;
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_low   = wr_en & hit_low;

    // Zero wait states; read data captured in setup
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata  = rdata_reg;

    // Counting qualifiers
    logic       run, tick, pre_hit, inc, step;
    logic [7:0] pre_mask;
    assign run = ctrl_reg.run_control & ~sleep_mode;
    assign tick = ctrl_reg.clock_source_select ? ext_tick_reg : 1'b1;
    assign pre_mask = 8'hff >> (3'd7 - ctrl_reg.prescale_ratio_select);
    assign pre_hit = ((pre_reg | ~pre_mask) == 8'hff);
    assign step = run & tick & (inh_reg == 2'd0);
    assign inc = step & (ctrl_reg.prescaler_assign | pre_hit);

    // Pin synchroniser, first stage read only by second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= external_count_input;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    // Edge pulse, registered once more for the increment delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_tick_reg <= 1'b0;
        end else begin
            ext_tick_reg <= ctrl_reg.edge_select ? (ext_prev_reg & ~ext_sync_reg)
                                                 : (~ext_prev_reg & ext_sync_reg);
        end
    end

    // Timer control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `TCZ_TCTL_RESET;
        end else if (wr_en && hit_tctl) begin
            ctrl_reg <= pwdata[7:0];
        end
    end

    // Write inhibit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_reg <= 2'd0;
        end else if (wr_low) begin
            inh_reg <= 2'(`TCZ_INH_CYCLES);
        end else if (inh_reg != 2'd0) begin
            inh_reg <= inh_reg - 2'd1;
        end
    end

    // Prescaler, never visible on the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 8'h00;
        end else if (wr_low && !ctrl_reg.prescaler_assign) begin
            pre_reg <= 8'h00;
        end else if (step && !ctrl_reg.prescaler_assign) begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    // Live count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {`TCZ_HIGH_RESET, `TCZ_LOW_RESET};
        end else if (wr_low) begin
            cnt_reg[7:0] <= pwdata[7:0];
            if (!ctrl_reg.width_select) begin
                cnt_reg[15:8] <= hbuf_reg;
            end
        end else if (inc) begin
            if (ctrl_reg.width_select) begin
                cnt_reg[7:0] <= cnt_reg[7:0] + 8'h01;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // High buffer, the only path to the upper byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hbuf_reg <= `TCZ_HIGH_RESET;
        end else if (wr_en && hit_high) begin
            hbuf_reg <= pwdata[7:0];
        end else if (rd_setup && hit_low && !ctrl_reg.width_select) begin
            hbuf_reg <= cnt_reg[15:8];
        end
    end

    // Overflow detection
    logic ovf;
    assign ovf = inc & (ctrl_reg.width_select ? (cnt_reg[7:0] == 8'hff)
                                              : (cnt_reg == 16'hffff));

    // Interrupt control; a wrap in the clearing cycle still sets the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= '0;
        end else begin
            if (wr_en && hit_ictl) begin
                irq_reg.overflow_irq_enable <= pwdata[`TCZ_ICTL_EN_BIT];
            end
            if (ovf) begin
                irq_reg.overflow_flag <= 1'b1;
            end else if (wr_en && hit_ictl) begin
                irq_reg.overflow_flag <= pwdata[`TCZ_ICTL_FLAG_BIT];
            end
        end
    end

    assign overflow_irq = irq_reg.overflow_flag & irq_reg.overflow_irq_enable;

    // Read data, taken in setup so it matches the high snapshot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            rdata_reg <= 32'h0000_0000;
            if (hit_low) begin
                rdata_reg[7:0] <= cnt_reg[7:0];
            end else if (hit_high) begin
                rdata_reg[7:0] <= hbuf_reg;
            end else if (hit_ictl) begin
                rdata_reg[`TCZ_ICTL_EN_BIT]   <= irq_reg.overflow_irq_enable;
                rdata_reg[`TCZ_ICTL_FLAG_BIT] <= irq_reg.overflow_flag;
            end else if (hit_tctl) begin
                rdata_reg[7:0] <= ctrl_reg;
            end
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic quiet;
    assign quiet = ~wr_en;

    sequence s_timer_tick;
        run && !ctrl_reg.clock_source_select && ctrl_reg.prescaler_assign
            && !ctrl_reg.width_select && inh_reg == 2'd0 && quiet;
    endsequence

    property p_timer_step;
        s_timer_tick |=> cnt_reg == $past(cnt_reg) + 16'h0001;
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("timer did not advance one per cycle");

    sequence s_low_write_then_quiet;
        wr_low ##1 quiet [*2];
    endsequence

    // Compared one edge after both stalled edges, against the value just written
    property p_write_stall;
        s_low_write_then_quiet |=> cnt_reg == $past(cnt_reg, 2);
    endproperty
    a_write_stall: assert property (p_write_stall)
        else $error("count moved during write stall");

    sequence s_rise_seen;
        ctrl_reg.clock_source_select && !ctrl_reg.edge_select
            && ctrl_reg.prescaler_assign && ctrl_reg.width_select
            && !ext_prev_reg && ext_sync_reg;
    endsequence

    property p_edge_count;
        s_rise_seen ##1 (run && inh_reg == 2'd0 && quiet && $stable(ctrl_reg))
            |=> cnt_reg[7:0] == $past(cnt_reg[7:0]) + 8'h01;
    endproperty
    a_edge_count: assert property (p_edge_count)
        else $error("rising pin edge not counted one cycle later");

    property p_pre_clear;
        wr_low && !ctrl_reg.prescaler_assign |=> pre_reg == 8'h00;
    endproperty
    a_pre_clear: assert property (p_pre_clear)
        else $error("prescaler not cleared by count write");

    property p_div_two;
        (run && !ctrl_reg.clock_source_select && !ctrl_reg.prescaler_assign
            && ctrl_reg.prescale_ratio_select == 3'd0 && !ctrl_reg.width_select
            && inh_reg == 2'd0 && quiet) [*2]
            |=> cnt_reg == $past(cnt_reg, 2) + 16'h0001;
    endproperty
    a_div_two: assert property (p_div_two)
        else $error("divide by two prescale wrong");

    property p_wrap8;
        inc && ctrl_reg.width_select && cnt_reg[7:0] == 8'hff && !wr_low
            |=> irq_reg.overflow_flag && cnt_reg[7:0] == 8'h00;
    endproperty
    a_wrap8: assert property (p_wrap8)
        else $error("eight-bit wrap did not set flag");

    property p_mask;
        !irq_reg.overflow_irq_enable |-> !overflow_irq;
    endproperty
    a_mask: assert property (p_mask)
        else $error("request raised while masked");

    property p_sleep_hold;
        sleep_mode && quiet |=> $stable(cnt_reg)
            && (!irq_reg.overflow_flag || $past(irq_reg.overflow_flag));
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("timer moved in sleep");

    property p_read_snap;
        rd_setup && hit_low && !ctrl_reg.width_select && !wr_en
            |=> hbuf_reg == $past(cnt_reg[15:8]);
    endproperty
    a_read_snap: assert property (p_read_snap)
        else $error("high buffer missed snapshot");

    property p_write_high;
        wr_low && !ctrl_reg.width_select |=> cnt_reg == {$past(hbuf_reg), $past(pwdata[7:0])};
    endproperty
    a_write_high: assert property (p_write_high)
        else $error("sixteen-bit write not atomic");

    property p_run_hold;
        !ctrl_reg.run_control && quiet |=> $stable(cnt_reg) && $stable(pre_reg);
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("count moved while stopped");

    property p_bypass_idle;
        ctrl_reg.prescaler_assign |=> $stable(pre_reg);
    endproperty
    a_bypass_idle: assert property (p_bypass_idle)
        else $error("prescaler moved while bypassed");

    property p_high_write;
        wr_en && hit_high && !inc
            |=> cnt_reg == $past(cnt_reg) && hbuf_reg == $past(pwdata[7:0]);
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("high write reached the live count");

endmodule : tcz_timer

/* File: common/tcz_regs.svh */
`ifndef TCZ_REGS_SVH
`define TCZ_REGS_SVH

// Register byte offsets on the APB window
`define TCZ_ADDR_W         12
`define TCZ_OFF_LOW        12'h000
`define TCZ_OFF_HIGH       12'h004
`define TCZ_OFF_ICTL       12'h008
`define TCZ_OFF_TCTL       12'h00c

// Reset values
`define TCZ_TCTL_RESET     8'hff
`define TCZ_HIGH_RESET     8'h00
`define TCZ_LOW_RESET      8'h00

// Interrupt control field positions
`define TCZ_ICTL_EN_BIT    5
`define TCZ_ICTL_FLAG_BIT  2

// Timing: instruction cycle and clock period in ns
`define TCZ_TCY_NS         50
`define TCZ_CLK_NS         50
`define TCZ_INH_TCY        2
`define TCZ_INH_CYCLES     (`TCZ_INH_TCY * `TCZ_TCY_NS / `TCZ_CLK_NS)

`endif

/* File: common/tcz_pkg.sv */
package tcz_pkg;

    // Timer control layout, bit 7 down to bit 0
    typedef struct packed {
        logic       run_control;
        logic       width_select;
        logic       clock_source_select;
        logic       edge_select;
        logic       prescaler_assign;
        logic [2:0] prescale_ratio_select;
    } tcz_ctrl_s;

    // Interrupt control state kept by this block
    typedef struct packed {
        logic overflow_irq_enable;
        logic overflow_flag;
    } tcz_irq_s;

    typedef logic [15:0] tcz_count_t;
    typedef logic [1:0]  tcz_inhibit_t;

endpackage : tcz_pkg

/* File: verification/tcz_ext_src.sv */
`timescale 1ns/1ps
// Source on the count pin; the level stands still between bursts
module tcz_ext_src (
    // Clock
    input  wire logic pclk,
    // Count pin
    output logic      pin
);
    initial pin = 1'b0;

    // slow level changes
    // A half period of several clocks, so the synchroniser sees each level
    task automatic toggle(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge pclk);
            pin <= ~pin;
        end
        repeat (half) @(posedge pclk);
    endtask : toggle
endmodule : tcz_ext_src

/* File: verification/tcz_timer_test.sv */
`timescale 1ns/1ps
`include "tcz_regs.svh"
module tcz_timer_test
    import tcz_pkg::*;
;
    localparam logic [11:0] a_lo = `TCZ_OFF_LOW;
    localparam logic [11:0] a_hi = `TCZ_OFF_HIGH;
    localparam logic [11:0] a_ic = `TCZ_OFF_ICTL;
    localparam logic [11:0] a_tc = `TCZ_OFF_TCTL;
    logic        pclk, presetn, psel, penable, pwrite, sleep_mode;
    logic        pready, pslverr, overflow_irq, ext_pin, err, lvl;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    tcz_ctrl_s   cfg;
    int          fails, check_count, cyc, w_edge, s_edge, lw_edge, x, v, n;

    // Clock and edge counter; counter moves on the far edge to avoid races
    initial begin
        pclk = 1'b0;
        cyc = 0;
        forever #25 pclk = ~pclk;
    end
    always @(negedge pclk) cyc <= cyc + 1;

    tcz_timer u_tcz_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_input(ext_pin), .sleep_mode(sleep_mode),
        .overflow_irq(overflow_irq));
    tcz_ext_src u_tcz_ext_src (.pclk(pclk), .pin(ext_pin));

    // Compare and count
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // One APB transfer; notes the setup and access edges for the model
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        s_edge = cyc;
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        if (pready !== 1'b1) begin
            fails++;
            end_sim();
        end else begin
            rd = prdata;
            err = pslverr;
            w_edge = cyc;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr_low(input int d);
        apb(1'b1, a_lo, d);
        lw_edge = w_edge;
    endtask : wr_low

    // Model: increments since the last low write, two stalled edges first
    function automatic int incs(input int div);
        int m;
        m = s_edge - lw_edge - 3;
        return (m > 0) ? m / div : 0;
    endfunction : incs

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sleep_mode = 1'b0;
        fails = 0;
        check_count = 0;
        void'($urandom(32'h577d));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        apb(1'b0, a_tc, 0);
        chk("tctl", rd, 32'hff);
        apb(1'b0, a_hi, 0);
        chk("high", rd, 32'h0);
        apb(1'b0, a_lo, 0);
        chk("low", rd, 32'h0);
        apb(1'b0, 12'h010, 0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        $display("test reset done");
        // Timer mode, no prescaler, write stall
        apb(1'b1, a_tc, 32'hc8);
        apb(1'b0, a_tc, 0);
        chk("tctl_rw", rd, 32'hc8);
        x = $urandom_range(0, 200);
        wr_low(x);
        apb(1'b0, a_lo, 0);
        chk("stall", rd, x);
        wr_low(x);
        repeat (5) @(posedge pclk);
        apb(1'b0, a_lo, 0);
        chk("timer", rd, x + incs(1));
        $display("test timer done");
        // Every ratio code, switched while running; mid-period sample
        for (int k = 0; k < 8; k++) begin
            n = 2 << k;
            cfg = '{1'b1, k[0], 1'b0, 1'b0, 1'b0, 3'(k)};
            apb(1'b1, a_tc, {24'h0, cfg});
            wr_low(0);
            repeat (2 * n + n / 2 + 1) @(posedge pclk);
            apb(1'b0, a_lo, 0);
            chk("prescaled", rd, incs(n));
        end
        $display("test prescaler done");
        // 8-bit wrap, flag, mask, stop
        apb(1'b1, a_tc, 32'hc8);
        apb(1'b1, a_ic, 0);
        wr_low(8'hfd);
        repeat (8) @(posedge pclk);
        apb(1'b1, a_tc, 32'h48);
        apb(1'b0, a_ic, 0);
        chk("flag8", rd, 32'h04);
        chk("irq_off", {31'h0, overflow_irq}, 32'h0);
        apb(1'b1, a_ic, 32'h24);
        @(negedge pclk);
        chk("irq_on", {31'h0, overflow_irq}, 32'h1);
        apb(1'b1, a_ic, 0);
        apb(1'b1, a_ic, 32'h20);
        @(negedge pclk);
        chk("irq_clr", {31'h0, overflow_irq}, 32'h0);
        apb(1'b0, a_lo, 0);
        v = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, a_lo, 0);
        chk("stopped", rd, v);
        // Sleep freezes the count
        apb(1'b1, a_tc, 32'hc8);
        sleep_mode <= 1'b1;
        apb(1'b0, a_lo, 0);
        v = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, a_lo, 0);
        chk("sleep", rd, v);
        sleep_mode <= 1'b0;
        $display("test overflow done");
        // 16-bit mode through the high buffer
        apb(1'b1, a_tc, 32'h88);
        x = $urandom_range(0, 254);
        apb(1'b1, a_hi, x);
        wr_low(8'hfe);
        repeat (3) @(posedge pclk);
        apb(1'b0, a_lo, 0);
        v = (x * 256 + 8'hfe) + incs(1);
        chk("low16", rd, v & 8'hff);
        apb(1'b0, a_hi, 0);
        chk("high16", rd, (v >> 8) & 8'hff);
        apb(1'b1, a_hi, 32'h55);
        apb(1'b0, a_hi, 0);
        chk("buffer", rd, 32'h55);
        apb(1'b1, a_ic, 0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, a_hi, k ? 32'hff : 32'h0);
            wr_low(8'hfc);
            repeat (10) @(posedge pclk);
            apb(1'b0, a_ic, 0);
            chk("flag16", rd, k ? 32'h04 : 32'h0);
        end
        $display("test wide done");
        // Pin mode, rising then falling edge, prompt then slow source
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, a_tc, e ? 32'hf8 : 32'he8);
            lvl = ext_pin;
            wr_low(0);
            u_tcz_ext_src.toggle(3, 3 + e);
            repeat (8) @(posedge pclk);
            apb(1'b0, a_lo, 0);
            chk("pin", rd, (lvl ^ e[0]) ? 32'h1 : 32'h2);
        end
        $display("test pin done");
        end_sim();
    end
endmodule : tcz_timer_test
